// *** pkg/exec_pkg.sv ***
/*
  Constants and types for the call / clear / complement execution unit.
  Assumes one core clock domain and an externally decoded operation code.
*/
package exec_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int PC_WIDTH   = 12;     // Program counter width
  localparam int DATA_WIDTH = 8;      // Data memory word width
  localparam int ADDR_WIDTH = 8;      // Data memory address width
  localparam int BIT_SEL_W  = 3;      // Bit index width

  // ---------------------------------------------------------------
  // Reset values and constants
  // ---------------------------------------------------------------
  localparam logic [PC_WIDTH-1:0]   PC_RESET   = 12'h000;
  localparam logic [DATA_WIDTH-1:0] BYTE_ZERO  = 8'h00;
  localparam logic [PC_WIDTH-1:0]   PC_STEP    = 12'h001;
  localparam logic [1:0]            CALL_CYCLES = 2'h2;

  // ---------------------------------------------------------------
  // Operation codes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NOP          = 3'b000,
    OP_CALL         = 3'b001,
    OP_CLEAR_BYTE   = 3'b010,
    OP_CLEAR_BIT    = 3'b011,
    OP_WDT_SINGLE   = 3'b100,
    OP_WDT_PRE_A    = 3'b101,
    OP_WDT_PRE_B    = 3'b110,
    OP_COMPLEMENT   = 3'b111
  } op_type;

  // Sequencer states
  typedef enum logic [0:0] {
    ST_FETCH = 1'b0,
    ST_CALL2 = 1'b1
  } state_type;

endpackage : exec_pkg

// *** design/preclear_tracker.sv ***
/*
  Tracks which watchdog pre-clear ran last and grants a clear
  only when the two pre-clear instructions alternate.
  Assumes its inputs are one-cycle strobes on the core clock.
*/
`timescale 1ns/1ps
module preclear_tracker (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic pre_a,     // Pre-clear A executing
  input  wire logic pre_b,     // Pre-clear B executing
  output logic      grant      // Combinational: clear allowed now
);
  import exec_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic last_b_reg;   // 1: B ran last, 0: A ran last
  logic valid_reg;    // Any pre-clear seen since reset
  logic last_b_next;
  logic valid_next;

  // Next state and grant; the first pre-clear after reset never grants
  always_comb begin
    last_b_next = last_b_reg;
    valid_next  = valid_reg;
    grant       = 1'b0;
    if (pre_a) begin
      grant       = valid_reg & last_b_reg;
      last_b_next = 1'b0;
      valid_next  = 1'b1;
    end else if (pre_b) begin
      grant       = valid_reg & ~last_b_reg;
      last_b_next = 1'b1;
      valid_next  = 1'b1;
    end
  end

  // Registers only
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      last_b_reg <= 1'b0;
      valid_reg  <= 1'b0;
    end else begin
      last_b_reg <= last_b_next;
      valid_reg  <= valid_next;
    end
  end

endmodule : preclear_tracker

// *** design/call_clear_exec.sv ***
/*
  Execution unit for call, clear, bit clear, watchdog clears and
  complement. Holds PC, a stack-push port, a small data memory,
  zero / timeout / powerdown flags and a watchdog-clear strobe.
  Assumes op_valid is a one-cycle request only when op_ready is high.
*/
// Function
// - Call pushes program counter plus one
// - Call loads target, flags untouched
// - Call takes two instruction cycles
// - Byte clear writes zero, flags untouched
// - Bit clear zeroes only selected bit
// - Single clear resets watchdog and flags
// - Pre-clears work only when alternated
// - Repeated same pre-clear does nothing
// - Complement inverts byte, writes back, zero
`timescale 1ns/1ps
module call_clear_exec #(
  parameter int MEM_DEPTH = 256          // Data memory bytes
) (
  input  wire logic                             clock,
  input  wire logic                             rst_n,
  input  wire logic                             op_valid,
  input  wire exec_pkg::op_type                 op_code,
  input  wire logic [exec_pkg::PC_WIDTH-1:0]    call_target,
  input  wire logic [exec_pkg::ADDR_WIDTH-1:0]  mem_addr,
  input  wire logic [exec_pkg::BIT_SEL_W-1:0]   bit_sel,
  input  wire logic                             timeout_set,
  input  wire logic                             powerdown_set,
  output logic                                  op_ready,
  output logic [exec_pkg::PC_WIDTH-1:0]         pc,
  output logic                                  stack_push,
  output logic [exec_pkg::PC_WIDTH-1:0]         stack_data,
  output logic                                  watchdog_clear,
  output logic                                  zero_flag,
  output logic                                  timeout_flag,
  output logic                                  powerdown_flag,
  output logic [exec_pkg::DATA_WIDTH-1:0]       rd_data
);
  import exec_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  state_type             state_reg, state_next;     // Sequencer
  logic                  ready_reg, ready_next;     // Ready for a request
  logic [PC_WIDTH-1:0]   pc_reg, pc_next;           // Program counter
  logic [PC_WIDTH-1:0]   target_reg, target_next;   // Held call target
  logic                  push_reg, push_next;       // Stack push strobe
  logic [PC_WIDTH-1:0]   sdata_reg, sdata_next;     // Pushed address
  logic                  wdclr_reg, wdclr_next;     // Watchdog strobe
  logic                  zero_reg, zero_next;       // Zero flag
  logic                  to_reg, to_next;           // Timeout flag
  logic                  pd_reg, pd_next;           // Powerdown flag
  logic [DATA_WIDTH-1:0] rd_reg, rd_next;           // Last byte result
  logic [DATA_WIDTH-1:0] mem_reg [MEM_DEPTH];       // Data memory
  logic [DATA_WIDTH-1:0] wr_byte;                   // Byte written back
  logic                  wr_en;                     // Memory write
  logic                  take;                      // Request accepted
  logic                  pre_grant;                 // Alternation ok
  logic [DATA_WIDTH-1:0] cur_byte;                  // Addressed byte

  assign take     = op_valid & (state_reg == ST_FETCH);
  assign cur_byte = mem_reg[mem_addr];

  // ---------------------------------------------------------------
  // Pre-clear alternation tracker
  // ---------------------------------------------------------------
  preclear_tracker preclear_tracker_inst (
    .clock (clock),
    .rst_n (rst_n),
    .pre_a (take & (op_code == OP_WDT_PRE_A)),
    .pre_b (take & (op_code == OP_WDT_PRE_B)),
    .grant (pre_grant)
  );

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // Hardware flag sets win over an instruction clear in the same cycle
  always_comb begin
    state_next  = state_reg;
    pc_next     = pc_reg;
    target_next = target_reg;
    push_next   = 1'b0;
    sdata_next  = sdata_reg;
    wdclr_next  = 1'b0;
    zero_next   = zero_reg;
    to_next     = to_reg;
    pd_next     = pd_reg;
    rd_next     = rd_reg;
    wr_en       = 1'b0;
    wr_byte     = cur_byte;
    case (state_reg)
      ST_FETCH: begin
        if (take) begin
          // Single-cycle ops advance the PC by one
          pc_next = pc_reg + PC_STEP;
          case (op_code)
            OP_CALL: begin
              push_next   = 1'b1;
              sdata_next  = pc_reg + PC_STEP;
              target_next = call_target;
              pc_next     = pc_reg;
              state_next  = ST_CALL2;
            end
            OP_CLEAR_BYTE: begin
              wr_en   = 1'b1;
              wr_byte = BYTE_ZERO;
              rd_next = BYTE_ZERO;
            end
            OP_CLEAR_BIT: begin
              wr_en   = 1'b1;
              wr_byte = cur_byte;
              wr_byte[bit_sel] = 1'b0;
              rd_next = wr_byte;
            end
            OP_WDT_SINGLE: begin
              wdclr_next = 1'b1;
              to_next    = 1'b0;
              pd_next    = 1'b0;
            end
            OP_WDT_PRE_A, OP_WDT_PRE_B: begin
              // Repeat of the same pre-clear leaves the watchdog strobe and flags alone
              if (pre_grant) begin
                wdclr_next = 1'b1;
                to_next    = 1'b0;
                pd_next    = 1'b0;
              end
            end
            OP_COMPLEMENT: begin
              wr_en     = 1'b1;
              wr_byte   = ~cur_byte;
              rd_next   = ~cur_byte;
              zero_next = (~cur_byte == BYTE_ZERO);
            end
            default: begin
              pc_next = pc_reg + PC_STEP;
            end
          endcase
        end
      end
      ST_CALL2: begin
        // Second cycle: jump, no flag touched
        pc_next    = target_reg;
        state_next = ST_FETCH;
      end
      default: begin
        state_next = ST_FETCH;
      end
    endcase
    // Ready is registered so the port comes straight from a flop
    ready_next = (state_next == ST_FETCH);
    if (timeout_set) begin
      to_next = 1'b1;
    end
    if (powerdown_set) begin
      pd_next = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Control state reset; memory contents are not reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg  <= ST_FETCH;
      ready_reg  <= 1'b1;
      pc_reg     <= PC_RESET;
      target_reg <= PC_RESET;
      push_reg   <= 1'b0;
      sdata_reg  <= PC_RESET;
      wdclr_reg  <= 1'b0;
      zero_reg   <= 1'b0;
      to_reg     <= 1'b0;
      pd_reg     <= 1'b0;
      rd_reg     <= BYTE_ZERO;
    end else begin
      state_reg  <= state_next;
      ready_reg  <= ready_next;
      pc_reg     <= pc_next;
      target_reg <= target_next;
      push_reg   <= push_next;
      sdata_reg  <= sdata_next;
      wdclr_reg  <= wdclr_next;
      zero_reg   <= zero_next;
      to_reg     <= to_next;
      pd_reg     <= pd_next;
      rd_reg     <= rd_next;
    end
  end

  // Data memory write port
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem_reg[mem_addr] <= wr_byte;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all from flip-flops
  // ---------------------------------------------------------------
  assign op_ready       = ready_reg;
  assign pc             = pc_reg;
  assign stack_push     = push_reg;
  assign stack_data     = sdata_reg;
  assign watchdog_clear = wdclr_reg;
  assign zero_flag      = zero_reg;
  assign timeout_flag   = to_reg;
  assign powerdown_flag = pd_reg;
  assign rd_data        = rd_reg;

endmodule : call_clear_exec

// *** verification/call_clear_exec_props.sv ***
/*
  Port checker for the call / clear / complement execution unit.
  Assumes one core clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module call_clear_exec_props
  import exec_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  rst_n,
  input wire logic                  op_valid,
  input wire exec_pkg::op_type      op_code,
  input wire logic [PC_WIDTH-1:0]   call_target,
  input wire logic [BIT_SEL_W-1:0]  bit_sel,
  input wire logic                  timeout_set,
  input wire logic                  powerdown_set,
  input wire logic                  op_ready,
  input wire logic [PC_WIDTH-1:0]   pc,
  input wire logic                  stack_push,
  input wire logic [PC_WIDTH-1:0]   stack_data,
  input wire logic                  watchdog_clear,
  input wire logic                  zero_flag,
  input wire logic                  timeout_flag,
  input wire logic                  powerdown_flag,
  input wire logic [DATA_WIDTH-1:0] rd_data
);
  // Request accepted on this edge
  wire take = op_valid && op_ready;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_call_push;
    take && op_code == OP_CALL |=>
      stack_push && stack_data == $past(pc) + PC_STEP;
  endproperty
  property p_call_pc;
    take && op_code == OP_CALL |=> !op_ready && $stable(zero_flag)
      ##1 op_ready && pc == $past(call_target, 2);
  endproperty
  property p_clr_byte;
    take && op_code == OP_CLEAR_BYTE |=>
      rd_data == BYTE_ZERO && $stable(zero_flag);
  endproperty
  property p_clr_bit;
    take && op_code == OP_CLEAR_BIT |=>
      !rd_data[$past(bit_sel)] && $stable(zero_flag);
  endproperty
  property p_single;
    take && op_code == OP_WDT_SINGLE && !timeout_set && !powerdown_set |=>
      watchdog_clear && !timeout_flag && !powerdown_flag;
  endproperty
  property p_cpl_zero;
    take && op_code == OP_COMPLEMENT |=> zero_flag == (rd_data == 8'h00);
  endproperty
  // Zero flag may only move after a complement
  property p_zero_cause;
    $past(rst_n) && $changed(zero_flag) |->
      $past(take && op_code == OP_COMPLEMENT);
  endproperty
  property p_push_cause;
    stack_push |-> $past(take && op_code == OP_CALL);
  endproperty
  // Only a watchdog instruction may pulse the clear
  property p_wd_cause;
    watchdog_clear |->
      $past(take && op_code inside {OP_WDT_SINGLE, OP_WDT_PRE_A,
                                    OP_WDT_PRE_B});
  endproperty
  // Same pre-clear twice in a row never clears
  property p_pre_repeat;
    take && op_code inside {OP_WDT_PRE_A, OP_WDT_PRE_B}
      ##1 take && op_code == $past(op_code) |=> !watchdog_clear;
  endproperty
  // ----------------------------------------
  // Assertions and covers
  // ----------------------------------------
  a_call_push: assert property (p_call_push)
    else $error("call push wrong");
  a_call_pc: assert property (p_call_pc)
    else $error("call target or timing wrong");
  a_clr_byte: assert property (p_clr_byte)
    else $error("byte clear wrong");
  a_clr_bit: assert property (p_clr_bit)
    else $error("bit clear wrong");
  a_single: assert property (p_single)
    else $error("single clear wrong");
  a_cpl_zero: assert property (p_cpl_zero)
    else $error("complement zero wrong");
  a_zero_cause: assert property (p_zero_cause)
    else $error("zero flag moved");
  a_push_cause: assert property (p_push_cause)
    else $error("stray push");
  a_wd_cause: assert property (p_wd_cause)
    else $error("stray watchdog clear");
  a_pre_repeat: assert property (p_pre_repeat)
    else $error("repeated pre-clear cleared");
  c_call: cover property (take && op_code == OP_CALL);
  c_pre: cover property (take && op_code == OP_WDT_PRE_B ##1 watchdog_clear);
  c_zero: cover property (take && op_code == OP_COMPLEMENT ##1 zero_flag);
endmodule : call_clear_exec_props

bind call_clear_exec call_clear_exec_props call_clear_exec_props_inst (
  .clock(clock), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
  .call_target(call_target), .bit_sel(bit_sel), .op_ready(op_ready),
  .timeout_set(timeout_set), .powerdown_set(powerdown_set),
  .pc(pc), .stack_push(stack_push), .stack_data(stack_data),
  .watchdog_clear(watchdog_clear), .zero_flag(zero_flag),
  .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
  .rd_data(rd_data)
);

// *** verification/test_call_clear_exec.sv ***
/*
  Self-checking bench for the execution unit.
  Assumes inputs change at the falling edge; outputs settle by then.
*/
`timescale 1ns/1ps
module test_call_clear_exec;
  import exec_pkg::*;
  logic clock = 0, rst_n = 0, op_valid = 0, timeout_set = 0;
  logic powerdown_set = 0, op_ready, stack_push, watchdog_clear;
  logic zero_flag, timeout_flag, powerdown_flag;
  op_type op_code = OP_NOP;
  logic [11:0] call_target = 0, pc, stack_data;
  logic [7:0] mem_addr = 0, rd_data, e;
  logic [2:0] bit_sel = 0;
  int error_cnt = 0, check_count = 0;
  call_clear_exec call_clear_exec_inst (.clock(clock), .rst_n(rst_n),
    .op_valid(op_valid), .op_code(op_code), .call_target(call_target),
    .mem_addr(mem_addr), .bit_sel(bit_sel), .timeout_set(timeout_set),
    .powerdown_set(powerdown_set), .op_ready(op_ready), .pc(pc),
    .stack_push(stack_push), .stack_data(stack_data),
    .watchdog_clear(watchdog_clear), .zero_flag(zero_flag),
    .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
    .rd_data(rd_data));
  initial begin
    forever #5 clock = ~clock;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(string n, logic [11:0] x, logic [11:0] g);
    check_count++;
    if (g !== x) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  // Valid stays high so ops can run back to back
  task automatic op(op_type c, logic [7:0] a, logic [2:0] b);
    op_valid = 1'b1; op_code = c; mem_addr = a; bit_sel = b;
    @(negedge clock);
  endtask : op
  task automatic idle;
    op_valid = 1'b0;
    @(negedge clock);
  endtask : idle
  // Hardware sets both watchdog flags
  task automatic raise;
    timeout_set = 1'b1; powerdown_set = 1'b1;
    @(negedge clock);
    timeout_set = 1'b0; powerdown_set = 1'b0;
    @(negedge clock);
  endtask : raise
  task automatic wchk(logic w, logic f);
    chk("wdog", w, watchdog_clear);
    chk("timeout", f, timeout_flag);
    chk("powerdown", f, powerdown_flag);
  endtask : wchk
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_call(logic [11:0] t, logic [11:0] from);
    call_target = t;
    op(OP_CALL, 8'h00, 3'h0);
    chk("push", 1, stack_push);
    chk("stack", from + 12'h001, stack_data);
    chk("ready", 0, op_ready);
    chk("pc hold", from, pc);
    idle();
    chk("pc", t, pc);
    chk("ready2", 1, op_ready);
    chk("push end", 0, stack_push);
    chk("zero", 0, zero_flag);
    $display("call test done");
  endtask : t_call
  task automatic t_wdt;
    raise();
    op(OP_WDT_PRE_A, 0, 0);
    wchk(0, 1);
    op(OP_WDT_PRE_A, 0, 0);
    wchk(0, 1);
    op(OP_WDT_PRE_B, 0, 0);
    wchk(1, 0);
    idle();
    raise();
    op(OP_WDT_PRE_B, 0, 0);
    wchk(0, 1);
    op(OP_WDT_PRE_A, 0, 0);
    wchk(1, 0);
    idle();
    raise();
    op(OP_WDT_SINGLE, 0, 0);
    wchk(1, 0);
    // A hardware set in the same cycle beats the clear
    timeout_set = 1'b1;
    powerdown_set = 1'b1;
    op(OP_WDT_SINGLE, 0, 0);
    wchk(1, 1);
    timeout_set = 1'b0;
    powerdown_set = 1'b0;
    idle();
    $display("watchdog test done");
  endtask : t_wdt
  task automatic t_mem;
    op(OP_CLEAR_BYTE, 8'h10, 0);
    chk("clr", 0, rd_data);
    chk("clr zero", 0, zero_flag);
    op(OP_COMPLEMENT, 8'h10, 0);
    chk("cpl", 8'hff, rd_data);
    e = 8'hff;
    for (int i = 0; i < 8; i++) begin
      op(OP_CLEAR_BIT, 8'h10, 3'(i));
      e[i] = 1'b0;
      chk("bit", e, rd_data);
      chk("zero kept", 0, zero_flag);
    end
    op(OP_COMPLEMENT, 8'h10, 0);
    chk("z0", 0, zero_flag);
    op(OP_COMPLEMENT, 8'h10, 0);
    chk("z1", 1, zero_flag);
    op(OP_CLEAR_BYTE, 8'h20, 0);
    chk("z kept", 1, zero_flag);
    op(OP_COMPLEMENT, 8'h10, 0);
    chk("mem", 8'hff, rd_data);
    // Every non-call step moves the counter on by one
    op(OP_NOP, 8'h00, 0);
    chk("pc step", 12'h015, pc);
    idle();
    $display("memory test done");
  endtask : t_mem
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  // Watchdog: whole run needs well under 2000 cycles
  initial begin
    #20000;
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    t_call(12'ha5c, 12'h000);
    t_call(12'hfff, 12'ha5c);
    t_wdt();
    t_mem();
    test_done();
  end
endmodule : test_call_clear_exec
